/* hdl/pcsla_lane.sv */
/*
 One PCS lane receive checker: block lock, marker tracking, BIP8 check.
 Assumes 66-bit blocks arrive on clk with a one-cycle valid strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsla_lane (
    input wire logic clk,
    input wire logic nrst,
    input wire logic blk_valid,
    input wire logic [1:0] blk_hdr,
    input wire logic [63:0] blk_data,
    input wire logic [23:0] marker_code,
    input wire logic [pcsla_pkg::INTERVAL_W-1:0] marker_interval_minus_one,
    output logic synced_ff,
    output logic sync_err_ff,
    output logic bip_err_ff,
    output logic spacing_err_ff,
    output logic repeat_err_ff,
    output logic format_err_ff,
    output logic loss_ff
);
    import pcsla_pkg::*;
    pcsla_lock_type state_ff;
    logic [6:0] good_cnt_ff, win_cnt_ff, bad_cnt_ff;
    logic [INTERVAL_W-1:0] gap_ff;
    logic [2:0] run_ff;
    logic [7:0] acc_ff, word_bip;
    logic seen_ff, lost_ff;
    logic hdr_ok, is_code, is_good, mk_act, loss_now, spacing_now, format_now, err_now;

    assign hdr_ok = (blk_hdr == HDR_DATA) || (blk_hdr == HDR_CTRL);
    assign is_code = (blk_hdr == HDR_CTRL) && (blk_data[23:0] == marker_code);
    assign is_good = is_code && (blk_data[55:32] == ~blk_data[23:0]);
    assign mk_act = blk_valid && (state_ff == LOCK_HELD);
    assign loss_now = mk_act && !hdr_ok && (bad_cnt_ff == WINDOW_BAD_LIMIT - 7'h1);
    assign spacing_now = mk_act && seen_ff && ((is_code && gap_ff != marker_interval_minus_one) ||
        (!is_code && gap_ff == marker_interval_minus_one));
    assign format_now = mk_act && is_code && !is_good;
    assign err_now = spacing_now || format_now;

    always_comb begin
        word_bip = 8'h00;
        for (int b = 0; b < 8; b++) begin
            word_bip = word_bip ^ blk_data[8*b +: 8];
        end
    end

    // Lock hunts on consecutive good headers, drops on too many bad in a window
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= LOCK_HUNT;
            good_cnt_ff <= 7'h00;
            win_cnt_ff <= 7'h00;
            bad_cnt_ff <= 7'h00;
        end else if (blk_valid) begin
            case (state_ff)
                LOCK_HUNT: begin
                    if (!hdr_ok) begin
                        good_cnt_ff <= 7'h00;
                    end else if (good_cnt_ff == LOCK_GOOD_CNT - 7'h1) begin
                        state_ff <= LOCK_HELD;
                        good_cnt_ff <= 7'h00;
                    end else begin
                        good_cnt_ff <= good_cnt_ff + 7'h1;
                    end
                end
                LOCK_HELD: begin
                    if (loss_now) begin
                        state_ff <= LOCK_HUNT;
                        win_cnt_ff <= 7'h00;
                        bad_cnt_ff <= 7'h00;
                    end else if (win_cnt_ff == WINDOW_CNT - 7'h1) begin
                        win_cnt_ff <= 7'h00;
                        bad_cnt_ff <= 7'h00;
                    end else begin
                        win_cnt_ff <= win_cnt_ff + 7'h1;
                        bad_cnt_ff <= bad_cnt_ff + {6'h00, !hdr_ok};
                    end
                end
                default: state_ff <= LOCK_HUNT;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seen_ff <= 1'b0;
            gap_ff <= '0;
            acc_ff <= 8'h00;
        end else if (state_ff != LOCK_HELD) begin
            seen_ff <= 1'b0;
            gap_ff <= '0;
            acc_ff <= 8'h00;
        end else if (mk_act) begin
            seen_ff <= seen_ff || is_good;
            // A missing marker restarts the spacing count at the slot it was due
            gap_ff <= (is_code || gap_ff == marker_interval_minus_one) ? '0 :
                gap_ff + {{(INTERVAL_W-1){1'b0}}, 1'b1};
            acc_ff <= is_code ? 8'h00 : (acc_ff ^ word_bip);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_ff <= 3'h0;
        end else if (err_now) begin
            run_ff <= (run_ff == REPEAT_LIMIT - 3'h1) ? 3'h0 : run_ff + 3'h1;
        end else if (mk_act && is_good) begin
            run_ff <= 3'h0;
        end
    end

    // Loss is remembered until the lane is synced again; a new loss wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lost_ff <= 1'b0;
        end else if (loss_now) begin
            lost_ff <= 1'b1;
        end else if (state_ff == LOCK_HELD && seen_ff) begin
            lost_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            synced_ff <= 1'b0;
            sync_err_ff <= 1'b0;
            bip_err_ff <= 1'b0;
            spacing_err_ff <= 1'b0;
            repeat_err_ff <= 1'b0;
            format_err_ff <= 1'b0;
            loss_ff <= 1'b0;
        end else begin
            synced_ff <= (state_ff == LOCK_HELD) && seen_ff;
            sync_err_ff <= lost_ff || ((state_ff == LOCK_HELD) && !seen_ff);
            bip_err_ff <= mk_act && is_good && seen_ff && (blk_data[31:24] != acc_ff);
            spacing_err_ff <= spacing_now;
            repeat_err_ff <= err_now && (run_ff == REPEAT_LIMIT - 3'h1);
            format_err_ff <= format_now;
            loss_ff <= loss_now;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    synced_cause_a: assert property (synced_ff |-> $past(state_ff == LOCK_HELD && seen_ff))
        else $error("sync flag without lock and marker");
    sync_drop_a: assert property ($fell(state_ff) |=> !synced_ff)
        else $error("sync flag stayed high after lock loss");
    sync_err_a: assert property ($fell(state_ff) |=> sync_err_ff)
        else $error("lock loss did not raise sync error");
    bip_cause_a: assert property (bip_err_ff |-> $past(is_good && mk_act) &&
        $past(blk_data[31:24]) != $past(acc_ff))
        else $error("parity error without bad signature");
    format_cause_a: assert property (format_err_ff |-> $past(is_code && !is_good && mk_act))
        else $error("format error without malformed marker");
    repeat_cause_a: assert property (repeat_err_ff |-> $past(run_ff) == 3'h3 && $past(err_now))
        else $error("repeat error before four marker errors");
endmodule : pcsla_lane
`default_nettype wire

/* hdl/pcsla_pkg.sv */
/*
 Constants for the PCS receive lane alignment status block: register map,
 field positions, reset values, lock and marker counts, scrambler taps.
 Assumes a 40 MHz clk; all lane data arrive synchronous to it.
*/
package pcsla_pkg;
    localparam int LANES = 4;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_INTERVAL = 12'h004;
    localparam logic [11:0] ADDR_LB_SEL = 12'h008;
    localparam logic [11:0] ADDR_LANE_STAT = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
    localparam logic [11:0] ADDR_IRQ_CLR = 12'h014;
    localparam logic [11:0] ADDR_IRQ_EN = 12'h018;
    localparam int CTRL_TEST_PAT_BIT = 0;
    localparam int CTRL_REM_LOOP_BIT = 1;
    localparam int INTERVAL_W = 16;
    localparam logic [15:0] INTERVAL_RST = 16'h3FFF;
    localparam int LB_SEL_W = 12;
    localparam int LB_SEL_W_SINGLE50 = 6;
    localparam int LANE_STAT_SYNCED_LSB = 0;
    localparam int LANE_STAT_ERR_LSB = 4;
    localparam int IRQ_W = 20;
    localparam int IRQ_BIP_LSB = 0;
    localparam int IRQ_SPACING_LSB = 4;
    localparam int IRQ_REPEAT_LSB = 8;
    localparam int IRQ_FORMAT_LSB = 12;
    localparam int IRQ_LOSS_LSB = 16;
    localparam logic [6:0] LOCK_GOOD_CNT = 7'h40;
    localparam logic [6:0] WINDOW_CNT = 7'h40;
    localparam logic [6:0] WINDOW_BAD_LIMIT = 7'h10;
    localparam logic [2:0] REPEAT_LIMIT = 3'h4;
    localparam logic [1:0] HDR_DATA = 2'h1;
    localparam logic [1:0] HDR_CTRL = 2'h2;
    localparam logic [63:0] IDLE_BLOCK = 64'h0000_0000_0000_001E;
    localparam int SCR_W = 58;
    localparam int SCR_TAP_A = 57;
    localparam int SCR_TAP_B = 38;
    localparam logic [57:0] SCR_SEED = 58'h3FF_FFFF_FFFF_FFFF;
    // Arbitrary per-lane marker codes, lane 0 in the low bits
    localparam logic [LANES-1:0][23:0] MARKER_CODE =
        {24'h44_5566, 24'h33_4455, 24'h22_3344, 24'h11_2233};
    typedef enum logic {
        LOCK_HUNT = 1'b0,
        LOCK_HELD = 1'b1
    } pcsla_lock_type;
endpackage : pcsla_pkg

/* hdl/pcsla_top.sv */
/*
 PCS receive lane alignment status block with APB registers, interrupt,
 transmit test pattern and remote loopback.
 Assumes receive blocks, transmit blocks and APB all run on clk; the
 reconfiguration clock is provided free-running by the system.
*/
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcsla_top #(
    parameter bit SINGLE_50G = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcsla_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata_ff,
    input wire logic [pcsla_pkg::LANES-1:0] rx_valid,
    input wire logic [2*pcsla_pkg::LANES-1:0] rx_hdr,
    input wire logic [64*pcsla_pkg::LANES-1:0] rx_data,
    input wire logic [pcsla_pkg::LANES-1:0] tx_in_valid,
    input wire logic [2*pcsla_pkg::LANES-1:0] tx_in_hdr,
    input wire logic [64*pcsla_pkg::LANES-1:0] tx_in_data,
    output logic [pcsla_pkg::LANES-1:0] tx_valid_ff,
    output logic [2*pcsla_pkg::LANES-1:0] tx_hdr_ff,
    output logic [64*pcsla_pkg::LANES-1:0] tx_data_ff,
    output logic [pcsla_pkg::LANES-1:0] synced,
    output logic [pcsla_pkg::LANES-1:0] sync_error,
    output logic [pcsla_pkg::LANES-1:0] bip_error,
    output logic [pcsla_pkg::LANES-1:0] marker_spacing_error,
    output logic [pcsla_pkg::LANES-1:0] marker_repeat_error,
    output logic [pcsla_pkg::LANES-1:0] marker_format_error,
    output logic [pcsla_pkg::LB_SEL_W-1:0] transceiver_loopback_select,
    output logic irq
);
    import pcsla_pkg::*;
    logic test_pat_ff, rem_loop_ff;
    logic [INTERVAL_W-1:0] marker_interval_minus_one;
    logic [LB_SEL_W-1:0] lb_sel_ff, lb_mask;
    logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff, irq_clr, irq_ev;
    logic [LANES-1:0] loss;
    logic [31:0] nxt_rdata;
    logic addr_hit, wr_en, rd_setup;
    logic [SCR_W-1:0] scr_ff [LANES];
    logic [SCR_W+63:0] scr_res [LANES];

    function automatic logic [SCR_W+63:0] scramble_word(
        input logic [63:0] d,
        input logic [SCR_W-1:0] s
    );
        logic [SCR_W-1:0] st;
        logic [63:0] q;
        st = s;
        q = 64'h0000_0000_0000_0000;
        for (int i = 0; i < 64; i++) begin
            q[i] = d[i] ^ st[SCR_TAP_A] ^ st[SCR_TAP_B];
            st = {st[SCR_W-2:0], q[i]};
        end
        return {st, q};
    endfunction : scramble_word

    // Receive status, one checker per lane
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        pcsla_lane u_lane (
            .clk(clk),
            .nrst(nrst),
            .blk_valid(rx_valid[l]),
            .blk_hdr(rx_hdr[2*l +: 2]),
            .blk_data(rx_data[64*l +: 64]),
            .marker_code(MARKER_CODE[l]),
            .marker_interval_minus_one(marker_interval_minus_one),
            .synced_ff(synced[l]),
            .sync_err_ff(sync_error[l]),
            .bip_err_ff(bip_error[l]),
            .spacing_err_ff(marker_spacing_error[l]),
            .repeat_err_ff(marker_repeat_error[l]),
            .format_err_ff(marker_format_error[l]),
            .loss_ff(loss[l])
        );
        assign scr_res[l] = scramble_word(IDLE_BLOCK, scr_ff[l]);
    end

    // APB slave: zero wait states, unmapped offsets answer with an error
    assign pready = 1'b1;
    always_comb begin
        addr_hit = 1'b1;
        nxt_rdata = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL: begin
                nxt_rdata[CTRL_TEST_PAT_BIT] = test_pat_ff;
                nxt_rdata[CTRL_REM_LOOP_BIT] = rem_loop_ff;
            end
            ADDR_INTERVAL: nxt_rdata[INTERVAL_W-1:0] = marker_interval_minus_one;
            ADDR_LB_SEL: nxt_rdata[LB_SEL_W-1:0] = transceiver_loopback_select;
            ADDR_LANE_STAT: begin
                nxt_rdata[LANE_STAT_SYNCED_LSB +: LANES] = synced;
                nxt_rdata[LANE_STAT_ERR_LSB +: LANES] = sync_error;
            end
            ADDR_IRQ_STAT: nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
            ADDR_IRQ_CLR: nxt_rdata = 32'h0000_0000;
            ADDR_IRQ_EN: nxt_rdata[IRQ_W-1:0] = irq_en_ff;
            default: addr_hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_hit;
    assign wr_en = psel && penable && pwrite && addr_hit;
    assign rd_setup = psel && !penable && !pwrite;
    assign irq_clr = (wr_en && paddr == ADDR_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;

    // Read data is captured in the setup phase so it is stable in the access phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            test_pat_ff <= 1'b0;
            rem_loop_ff <= 1'b0;
            marker_interval_minus_one <= INTERVAL_RST;
            lb_sel_ff <= '0;
            irq_en_ff <= '0;
        end else if (wr_en) begin
            case (paddr)
                ADDR_CTRL: begin
                    test_pat_ff <= pwdata[CTRL_TEST_PAT_BIT];
                    rem_loop_ff <= pwdata[CTRL_REM_LOOP_BIT];
                end
                ADDR_INTERVAL: marker_interval_minus_one <= pwdata[INTERVAL_W-1:0];
                ADDR_LB_SEL: lb_sel_ff <= pwdata[LB_SEL_W-1:0];
                ADDR_IRQ_EN: irq_en_ff <= pwdata[IRQ_W-1:0];
                default: test_pat_ff <= test_pat_ff;
            endcase
        end
    end

    // A single 50G core drives only the low six select bits
    assign lb_mask = SINGLE_50G ? {{(LB_SEL_W-LB_SEL_W_SINGLE50){1'b0}},
        {LB_SEL_W_SINGLE50{1'b1}}} : {LB_SEL_W{1'b1}};
    assign transceiver_loopback_select = lb_sel_ff & lb_mask;

    // Interrupt: sticky events, write-one-to-clear, a new event beats its clear
    assign irq_ev = {loss, marker_format_error, marker_repeat_error,
        marker_spacing_error, bip_error};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
        end
    end
    assign irq = |(irq_stat_ff & irq_en_ff);

    // Transmit path is a group of its own, fed only from tx inputs, looped rx or the scrambled test pattern
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_valid_ff <= '0;
            tx_hdr_ff <= '0;
            tx_data_ff <= '0;
            for (int l = 0; l < LANES; l++) begin
                scr_ff[l] <= SCR_SEED;
            end
        end else if (test_pat_ff) begin
            // Test pattern has priority over remote loopback
            for (int l = 0; l < LANES; l++) begin
                tx_valid_ff[l] <= 1'b1;
                tx_hdr_ff[2*l +: 2] <= HDR_CTRL;
                tx_data_ff[64*l +: 64] <= scr_res[l][63:0];
                scr_ff[l] <= scr_res[l][SCR_W+63:64];
            end
        end else if (rem_loop_ff) begin
            tx_valid_ff <= rx_valid;
            tx_hdr_ff <= rx_hdr;
            tx_data_ff <= rx_data;
        end else begin
            tx_valid_ff <= tx_in_valid;
            tx_hdr_ff <= tx_in_hdr;
            tx_data_ff <= tx_in_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    test_pattern_a: assert property (test_pat_ff |=> tx_valid_ff == {LANES{1'b1}} &&
        tx_hdr_ff == {LANES{HDR_CTRL}})
        else $error("test pattern not sending idle control blocks");
    test_scramble_a: assert property (test_pat_ff |=> tx_data_ff[63:0] != IDLE_BLOCK)
        else $error("idle block left unscrambled");
    remote_loop_a: assert property (!test_pat_ff && rem_loop_ff |=>
        tx_data_ff == $past(rx_data) && tx_valid_ff == $past(rx_valid))
        else $error("remote loopback did not return receive data");
    loop_sel_a: assert property (SINGLE_50G |->
        transceiver_loopback_select[LB_SEL_W-1:LB_SEL_W_SINGLE50] == '0)
        else $error("upper loopback select bits driven on single 50G");
    irq_sticky_a: assert property (irq_stat_ff[0] && !irq_clr[0] |=> irq_stat_ff[0])
        else $error("status bit lost without a clear");
    irq_event_a: assert property (bip_error[0] |=> irq_stat_ff[IRQ_BIP_LSB])
        else $error("parity event not recorded");

    all_synced_c: cover property ($rose(synced == {LANES{1'b1}}));
    repeat_err_c: cover property (|marker_repeat_error);
    irq_c: cover property ($rose(irq));
    clr_race_c: cover property (|(irq_clr & irq_ev));
endmodule : pcsla_top
`default_nettype wire

/* tb/pcsla_lane_src.sv */
/*
 Far side model: four receive lanes sending 66-bit blocks every cycle,
 with lane markers every interval+1 blocks and optional injected faults.
 Assumes the bench drives the fault levels at clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsla_lane_src (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] interval,
    input wire logic bad_hdr,
    input wire logic bad_bip,
    input wire logic bad_fmt,
    input wire logic bad_gap,
    output logic [3:0] rx_valid,
    output logic [7:0] rx_hdr,
    output logic [255:0] rx_data
);
    import pcsla_pkg::*;
    logic [15:0] gap_ff;
    logic [7:0] bip_ff;
    logic [63:0] pat_ff;
    logic mark;
    logic [7:0] fold;
    // A late marker leaves one extra data block in the gap
    assign mark = (gap_ff == interval + {15'h0, bad_gap});
    always_comb begin
        fold = 8'h00;
        for (int b = 0; b < 8; b++) begin
            fold = fold ^ pat_ff[8*b +: 8];
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap_ff <= 16'h0000;
            bip_ff <= 8'h00;
            pat_ff <= 64'h0123_4567_89AB_CDEF;
            rx_valid <= 4'h0;
            rx_hdr <= 8'h00;
            rx_data <= 256'h0;
        end else begin
            rx_valid <= 4'hF;
            pat_ff <= {pat_ff[62:0], pat_ff[63] ^ pat_ff[60]};
            for (int l = 0; l < LANES; l++) begin
                if (mark) begin
                    rx_hdr[2*l +: 2] <= HDR_CTRL;
                    rx_data[64*l +: 64] <= {8'h00, ~MARKER_CODE[l] ^ {23'h0, bad_fmt},
                        bip_ff ^ {7'h0, bad_bip}, MARKER_CODE[l]};
                end else begin
                    rx_hdr[2*l +: 2] <= bad_hdr ? 2'h0 : HDR_DATA;
                    rx_data[64*l +: 64] <= pat_ff;
                end
            end
            gap_ff <= mark ? 16'h0000 : gap_ff + 16'h0001;
            bip_ff <= mark ? 8'h00 : bip_ff ^ fold;
        end
    end
endmodule : pcsla_lane_src
`default_nettype wire

/* tb/pcsla_top_test.sv */
/*
 Self-checking bench for the lane status block: APB access, lane faults,
 interrupt, transmit test pattern and loopback.
 Assumes the lane source model and one 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsla_top_test;
    import pcsla_pkg::*;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_ff, rdat;
    logic [3:0] rx_valid, tx_valid_ff, synced, sync_error, bip_error;
    logic [3:0] marker_spacing_error, marker_repeat_error, marker_format_error;
    logic [7:0] rx_hdr, tx_hdr_ff;
    logic [255:0] rx_data, tx_data_ff, save;
    logic [11:0] transceiver_loopback_select;
    logic bad_hdr, bad_bip, bad_fmt, bad_gap;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;

    pcsla_top u_pcsla_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata_ff(prdata_ff), .rx_valid(rx_valid), .rx_hdr(rx_hdr),
        .rx_data(rx_data), .tx_in_valid(4'h5), .tx_in_hdr(8'h66), .tx_in_data(256'h0),
        .tx_valid_ff(tx_valid_ff), .tx_hdr_ff(tx_hdr_ff), .tx_data_ff(tx_data_ff),
        .synced(synced), .sync_error(sync_error), .bip_error(bip_error),
        .marker_spacing_error(marker_spacing_error),
        .marker_repeat_error(marker_repeat_error),
        .marker_format_error(marker_format_error),
        .transceiver_loopback_select(transceiver_loopback_select), .irq(irq));
    pcsla_lane_src u_pcsla_lane_src (.clk(clk), .nrst(nrst), .interval(16'h0007),
        .bad_hdr(bad_hdr), .bad_bip(bad_bip), .bad_fmt(bad_fmt), .bad_gap(bad_gap),
        .rx_valid(rx_valid), .rx_hdr(rx_hdr), .rx_data(rx_data));

    // One free-running clock also stands in for the reconfiguration clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        // Whole run needs about 190 cycles
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout ends a slave that never answers
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata_ff;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [3:0] pick(input int sel);
        case (sel)
            0: return bip_error;
            1: return marker_spacing_error;
            2: return marker_repeat_error;
            3: return marker_format_error;
            4: return synced;
            default: return sync_error;
        endcase
    endfunction : pick

    // Waits for a lane status vector to go non-zero, then compares it
    task wait_ev(input int sel, input logic [3:0] exp);
        logic [3:0] v;
        for (int i = 0; i < 600; i++) begin
            @(negedge clk);
            v = pick(sel);
            if (v !== 4'h0) break;
        end
        chk("lane status", {28'h0, v}, {28'h0, exp});
    endtask : wait_ev

    task set_fault(input int k, input logic v);
        @(posedge clk);
        case (k)
            0: bad_bip <= v;
            1: bad_gap <= v;
            2: bad_fmt <= v;
            default: bad_hdr <= v;
        endcase
    endtask : set_fault

    initial begin
        nrst = 1'b0;
        {psel, penable, pwrite, bad_hdr, bad_bip, bad_fmt, bad_gap} = 7'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, ADDR_INTERVAL, 32'h0);
        chk("interval", rdat, {16'h0, INTERVAL_RST});
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slverr", {31'h0, perr}, 32'h1);
        chk("unmapped", rdat, 32'h0);
        apb(1'b1, ADDR_LB_SEL, 32'h0000_0ABC);
        apb(1'b0, ADDR_LB_SEL, 32'h0);
        chk("lbsel", rdat, 32'h0000_0ABC);
        chk("lbsel port", {20'h0, transceiver_loopback_select}, 32'h0000_0ABC);
        apb(1'b1, ADDR_INTERVAL, 32'h0000_0007);
        apb(1'b1, ADDR_IRQ_EN, 32'h000F_FFFF);
        wait_ev(5, 4'hF);
        wait_ev(4, 4'hF);
        chk("sync err", {28'h0, sync_error}, 32'h0);
        apb(1'b1, ADDR_LANE_STAT, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_LANE_STAT, 32'h0);
        chk("lane stat", rdat, 32'h0000_000F);
        set_fault(0, 1'b1);
        wait_ev(0, 4'hF);
        set_fault(0, 1'b0);
        @(negedge clk);
        chk("bip one cycle", {28'h0, bip_error}, 32'h0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("irq stat", rdat, 32'h0000_000F);
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_IRQ_EN, 32'h0);
        @(negedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_IRQ_CLR, 32'h000F_FFFF);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("irq clr", rdat, 32'h0);
        apb(1'b1, ADDR_IRQ_EN, 32'h000F_FFFF);
        set_fault(1, 1'b1);
        wait_ev(1, 4'hF);
        set_fault(1, 1'b0);
        set_fault(2, 1'b1);
        wait_ev(3, 4'hF);
        wait_ev(2, 4'hF);
        set_fault(2, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        // Control lands at the access edge, the transmit register one edge later
        repeat (2) @(negedge clk);
        chk("pattern valid", {28'h0, tx_valid_ff}, 32'h0000_000F);
        chk("pattern hdr", {24'h0, tx_hdr_ff}, 32'h0000_00AA);
        apb(1'b1, ADDR_CTRL, 32'h2);
        repeat (2) @(negedge clk);
        save = rx_data;
        @(negedge clk);
        chk("loopback", tx_data_ff[223:192], save[223:192]);
        apb(1'b1, ADDR_CTRL, 32'h3);
        repeat (2) @(negedge clk);
        chk("pattern first", {24'h0, tx_hdr_ff}, 32'h0000_00AA);
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (2) @(negedge clk);
        chk("normal tx", {20'h0, tx_valid_ff, tx_hdr_ff}, 32'h0000_0566);
        set_fault(3, 1'b1);
        wait_ev(5, 4'hF);
        chk("sync drop", {28'h0, synced}, 32'h0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("loss stat", rdat & 32'h000F_0000, 32'h000F_0000);
        set_fault(3, 1'b0);
        report_and_stop();
    end
endmodule : pcsla_top_test
`default_nettype wire
